//--- snvc_host_model.sv
// Host model: a two-wire bus controller that drives scl and pulls sda low.
// Assumes the bench resolves sda with a pull-up; scl idles high between frames.
`timescale 1ns/1ps
`default_nettype none

module snvc_host_model (
  // Bus lines
  output logic scl,
  output logic sda_oe,
  input wire logic sda_in
);
  localparam realtime Q = 31.25;

  // ==========================================================================
  // Idle bus: clock stands high, data released
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end

  // ==========================================================================
  // Frame tasks; sda only moves while scl is low, except start and stop
  task automatic bus_start();
    #Q sda_oe = 1'b0;
    #Q scl = 1'b1;
    #Q sda_oe = 1'b1;
    #Q scl = 1'b0;
  endtask

  task automatic bus_stop();
    #Q sda_oe = 1'b1;
    #Q scl = 1'b1;
    #Q sda_oe = 1'b0;
    #Q;
  endtask

  // Byte out MSB first, then sample the target's acknowledge
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #Q sda_oe = ~b[i];
      #Q scl = 1'b1;
      #(2 * Q) scl = 1'b0;
    end
    #Q sda_oe = 1'b0;
    #Q scl = 1'b1;
    ack = ~sda_in;
    #(2 * Q) scl = 1'b0;
  endtask

  // Byte in, sampled on the rising edge, then acknowledge or not
  task automatic get_byte(input logic ack_in, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      #Q sda_oe = 1'b0;
      #Q scl = 1'b1;
      b[i] = sda_in;
      #(2 * Q) scl = 1'b0;
    end
    #Q sda_oe = ack_in;
    #Q scl = 1'b1;
    #(2 * Q) scl = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- snvc_pkg.sv
// Package for the serial memory and processor companion target.
// Assumes a 40 MHz system clock and a bus clock that runs only during frames.
package snvc_pkg;

  // ==========================================================================
  // Companion register offsets
  localparam logic [4:0] REG_FLAGS = 5'h09;
  localparam logic [4:0] REG_WDOG = 5'h0A;
  localparam logic [4:0] REG_PROT = 5'h0B;
  localparam logic [4:0] REG_EVCTL = 5'h0C;
  localparam logic [4:0] REG_C1L = 5'h0D;
  localparam logic [4:0] REG_C1H = 5'h0E;
  localparam logic [4:0] REG_C2L = 5'h0F;
  localparam logic [4:0] REG_C2H = 5'h10;
  localparam logic [4:0] REG_SN_LO = 5'h11;
  localparam logic [4:0] REG_SN_HI = 5'h18;

  // ==========================================================================
  // Field positions
  localparam int FLG_WTR = 7;
  localparam int FLG_POR = 6;
  localparam int WD_EN = 7;
  localparam int PR_SNL = 7;
  localparam int PR_WP1 = 4;
  localparam int PR_WP0 = 3;
  localparam int EV_C1P = 0;
  localparam int EV_C2P = 1;
  localparam int EV_CC = 2;
  localparam int EV_RC = 3;
  localparam logic [3:0] KICK_PATTERN = 4'hA;
  localparam logic [4:0] WD_OFF = 5'h1F;

  // ==========================================================================
  // Target identifiers (arbitrary values)
  localparam logic [3:0] MEM_ID = 4'hA;
  localparam logic [3:0] CMP_ID = 4'hD;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] WDOG_RST = 8'h00;
  localparam logic [7:0] PROT_RST = 8'h00;
  localparam logic [2:0] EVCTL_RST = 3'h0;

  // ==========================================================================
  // Timing
  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_MS = 100;
  localparam int TICK_CYCLES = TICK_MS * (CLK_HZ / 1000);
  localparam int DEB_US = 1000;
  localparam int DEB_CYCLES = DEB_US * (CLK_HZ / 1_000_000);
  localparam logic [1:0] RESET_TICKS = 2'h1;
  localparam int TMR_W = 24;

  // ==========================================================================
  // Types
  typedef enum logic [5:0] {
    L_IDLE = 6'h01,
    L_ADDR = 6'h02,
    L_AHI = 6'h04,
    L_ALO = 6'h08,
    L_WR = 6'h10,
    L_RD = 6'h20
  } snvc_lst_t;

  typedef struct packed {
    logic vdd_s1, vdd_s2, mr_s1, mr_s2, bk_s1, bk_s2;
    logic [1:0] ev_s1, ev_s2, ev_s3;
    logic wr_s1, wr_s2, wr_s3, rd_s1, rd_s2, rd_s3;
    logic [TMR_W-1:0] pre, deb;
    logic rst_oe, rst_o;
    logic [1:0] rst_cnt;
    logic [4:0] wd_cnt, wd_lim;
    logic wtr, por;
    logic [7:0] r0a, r0b, rd_data;
    logic [2:0] r0c;
    logic [15:0] c1, c2;
    logic [31:0] snap;
    logic [63:0] sn;
  } snvc_sys_t;

  typedef struct packed {
    snvc_lst_t st;
    logic [3:0] bitc;
    logic [7:0] sh, hi;
    logic tgt_cmp, rw, drive, start_seen;
    logic [14:0] mptr;
    logic [4:0] rptr;
    logic lk_s1, lk_s2;
    logic [1:0] wp_s1, wp_s2, a_s1, a_s2;
    logic wr_tgl, rd_tgl;
    logic [4:0] wr_addr, rd_addr;
    logic [7:0] wr_data;
  } snvc_link_t;

endpackage

//--- snvc_top.sv
// Two-wire target with a byte memory and a companion register bank.
// Assumes scl stands still between frames and analog comparators outside.
// What this block does
// - Hold reset while supply low, plus 100 ms
// - Watchdog timeout programmable 100 ms to 3 s
// - Unkicked enabled watchdog pulses reset 100 ms
// - Flags record supply/manual or watchdog reset source
// - Two 16-bit counters count selected edge polarity
// - Counters keep counting on backup supply
// - Answer only when select pins match address
// - Sample on scl rise, drive after fall
// - Memory and companion are separate bus targets
// - Companion accesses leave memory pointer alone
// - Sixteen byte registers configure the companion
// - Memory writes carry a two-byte address
// - Memory holds 512 to 32768 bytes
// - Memory writes complete at bus speed
// - Two protect bits in 0Bh set region
// - Protected bytes are not stored, not acknowledged
// - Reset pin input is filtered and debounced
// - Trip point chosen among four thresholds
// - Serial number lock is permanent once set
// - Protect codes: none, quarter, half, all
// - Manual low makes device drive reset 100 ms
// - Only 1010b in 09h restarts the watchdog
// - Bus locked out while reset is asserted
`timescale 1ns/1ps
`default_nettype none

module snvc_top #(
  parameter int MEM_BYTES = 512,
  parameter int TICK_CYCLES = snvc_pkg::TICK_CYCLES,
  parameter int DEB_CYCLES = snvc_pkg::DEB_CYCLES
) (
  // System clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Two-wire link
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [1:0] target_select_pins,
  // Supervisor
  input wire logic vdd_ok,
  output logic [1:0] trip_select,
  input wire logic rst_pin_in,
  output logic rst_pin_o,
  output logic rst_pin_oe,
  // Event counters and backup supply
  input wire logic [1:0] event_edge_inputs,
  input wire logic backup_supply_pin
);

  localparam int AW = $clog2(MEM_BYTES);

  snvc_pkg::snvc_sys_t s;
  snvc_pkg::snvc_sys_t next_s;
  snvc_pkg::snvc_link_t l;
  snvc_pkg::snvc_link_t next_l;
  logic [7:0] mem [MEM_BYTES];
  logic start_tgl;
  logic mem_we;
  logic [7:0] ld_byte;
  logic [7:0] byte_in;
  logic [31:0] hlen;

  // Read multiplexer of the companion bank
  function automatic logic [7:0] snvc_rd(input logic [4:0] a, input snvc_pkg::snvc_sys_t r);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      snvc_pkg::REG_FLAGS: v = {r.wtr, r.por, 6'h00};
      snvc_pkg::REG_WDOG: v = r.r0a;
      snvc_pkg::REG_PROT: v = r.r0b;
      snvc_pkg::REG_EVCTL: v = {5'h00, r.r0c};
      snvc_pkg::REG_C1L: v = r.snap[7:0];
      snvc_pkg::REG_C1H: v = r.snap[15:8];
      snvc_pkg::REG_C2L: v = r.snap[23:16];
      snvc_pkg::REG_C2H: v = r.snap[31:24];
      default: begin
        if (a >= snvc_pkg::REG_SN_LO && a <= snvc_pkg::REG_SN_HI) begin
          v = r.sn[8 * 32'(a - snvc_pkg::REG_SN_LO) +: 8];
        end
      end
    endcase
    return v;
  endfunction

  // Write protection by region code
  function automatic logic snvc_prot(input logic [AW-1:0] a, input logic [1:0] wp);
    logic p;
    p = 1'b0;
    case (wp)
      2'h1: p = (a[AW-1:AW-2] == 2'h0);
      2'h2: p = ~a[AW-1];
      2'h3: p = 1'b1;
      default: p = 1'b0;
    endcase
    return p;
  endfunction

  // ==========================================================================
  // System domain: supervisor, watchdog, counters, registers
  logic tick, manual, wd_exp, wr_go, rd_go, ctr_wr, pwr;
  logic [1:0] rise, fall, hit;
  logic [4:0] lim;
  logic [7:0] d;

  // Next state of the system domain
  always_comb begin
    next_s = s;
    next_s.vdd_s1 = vdd_ok;
    next_s.vdd_s2 = s.vdd_s1;
    next_s.mr_s1 = rst_pin_in;
    next_s.mr_s2 = s.mr_s1;
    next_s.bk_s1 = backup_supply_pin;
    next_s.bk_s2 = s.bk_s1;
    next_s.ev_s1 = event_edge_inputs;
    next_s.ev_s2 = s.ev_s1;
    next_s.ev_s3 = s.ev_s2;
    next_s.wr_s1 = l.wr_tgl;
    next_s.wr_s2 = s.wr_s1;
    next_s.wr_s3 = s.wr_s2;
    next_s.rd_s1 = l.rd_tgl;
    next_s.rd_s2 = s.rd_s1;
    next_s.rd_s3 = s.rd_s2;
    wr_go = s.wr_s2 ^ s.wr_s3;
    rd_go = s.rd_s2 ^ s.rd_s3;
    d = l.wr_data;
    // Shared 100 ms time base
    tick = (s.pre == snvc_pkg::TMR_W'(TICK_CYCLES - 1));
    next_s.pre = tick ? '0 : s.pre + 1'b1;
    // Debounce of the reset pin while not driving it
    if (s.mr_s2 || s.rst_oe) begin
      next_s.deb = '0;
    end else if (s.deb != snvc_pkg::TMR_W'(DEB_CYCLES)) begin
      next_s.deb = s.deb + 1'b1;
    end
    manual = !s.rst_oe && (s.deb == snvc_pkg::TMR_W'(DEB_CYCLES - 1));
    // Watchdog counter and expiry
    lim = (s.wd_lim == 5'h00) ? 5'h01 : s.wd_lim;
    wd_exp = tick && s.r0a[snvc_pkg::WD_EN] && (s.wd_lim != snvc_pkg::WD_OFF)
      && ((s.wd_cnt + 5'h01) >= lim) && !s.rst_oe;
    if (tick && s.wd_cnt != 5'h1F) begin
      next_s.wd_cnt = s.wd_cnt + 5'h01;
    end
    // Register writes from the link
    ctr_wr = 1'b0;
    if (wr_go) begin
      case (l.wr_addr)
        snvc_pkg::REG_FLAGS: begin
          next_s.wtr = s.wtr & d[snvc_pkg::FLG_WTR];
          next_s.por = s.por & d[snvc_pkg::FLG_POR];
          if (d[3:0] == snvc_pkg::KICK_PATTERN) begin
            next_s.wd_cnt = 5'h00;
            next_s.wd_lim = s.r0a[4:0];
          end
        end
        snvc_pkg::REG_WDOG: next_s.r0a = d;
        snvc_pkg::REG_PROT: next_s.r0b = {s.r0b[snvc_pkg::PR_SNL] | d[7], d[6:0]};
        snvc_pkg::REG_EVCTL: begin
          next_s.r0c = d[2:0];
          if (d[snvc_pkg::EV_RC]) begin
            next_s.snap = {s.c2, s.c1};
          end
        end
        snvc_pkg::REG_C1L: begin
          next_s.c1[7:0] = d;
          ctr_wr = 1'b1;
        end
        snvc_pkg::REG_C1H: begin
          next_s.c1[15:8] = d;
          ctr_wr = 1'b1;
        end
        snvc_pkg::REG_C2L: begin
          next_s.c2[7:0] = d;
          ctr_wr = 1'b1;
        end
        snvc_pkg::REG_C2H: begin
          next_s.c2[15:8] = d;
          ctr_wr = 1'b1;
        end
        default: begin
          if (l.wr_addr >= snvc_pkg::REG_SN_LO && l.wr_addr <= snvc_pkg::REG_SN_HI
              && !s.r0b[snvc_pkg::PR_SNL]) begin
            next_s.sn[8 * 32'(l.wr_addr - snvc_pkg::REG_SN_LO) +: 8] = d;
          end
        end
      endcase
    end
    // Reset sources; flag sets follow the clears so a set wins
    if (!s.vdd_s2) begin
      next_s.rst_oe = 1'b1;
      next_s.rst_cnt = snvc_pkg::RESET_TICKS;
      next_s.pre = '0;
      next_s.wd_cnt = 5'h00;
      next_s.por = 1'b1;
    end else if (manual || wd_exp) begin
      next_s.rst_oe = 1'b1;
      next_s.rst_cnt = snvc_pkg::RESET_TICKS;
      next_s.pre = '0;
      // Both sources in one cycle leave both flags set
      if (manual) begin
        next_s.por = 1'b1;
      end
      if (wd_exp) begin
        next_s.wtr = 1'b1;
      end
    end else if (s.rst_oe && tick) begin
      next_s.rst_cnt = s.rst_cnt - 2'h1;
      if (s.rst_cnt == 2'h1) begin
        next_s.rst_oe = 1'b0;
        next_s.wd_cnt = 5'h00;
      end
    end
    // Event counters, live on either supply
    pwr = s.vdd_s2 || s.bk_s2;
    rise = s.ev_s2 & ~s.ev_s3;
    fall = ~s.ev_s2 & s.ev_s3;
    hit[0] = s.r0c[snvc_pkg::EV_C1P] ? rise[0] : fall[0];
    hit[1] = s.r0c[snvc_pkg::EV_C2P] ? rise[1] : fall[1];
    if (pwr && !ctr_wr) begin
      if (s.r0c[snvc_pkg::EV_CC]) begin
        if (hit[0]) begin
          {next_s.c2, next_s.c1} = {s.c2, s.c1} + 32'h0000_0001;
        end
      end else begin
        if (hit[0]) begin
          next_s.c1 = s.c1 + 16'h0001;
        end
        if (hit[1]) begin
          next_s.c2 = s.c2 + 16'h0001;
        end
      end
    end
    // Read data for the link, captured on each request
    if (rd_go) begin
      next_s.rd_data = snvc_rd(l.rd_addr, s);
    end
  end

  // System domain register; counters reset only at power-on
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.rst_oe <= 1'b1;
      s.rst_cnt <= snvc_pkg::RESET_TICKS;
      s.por <= 1'b1;
      s.r0a <= snvc_pkg::WDOG_RST;
      s.r0b <= snvc_pkg::PROT_RST;
      s.r0c <= snvc_pkg::EVCTL_RST;
    end else begin
      s <= next_s;
    end
  end

  // Supervisor outputs
  assign rst_pin_oe = s.rst_oe;
  assign rst_pin_o = s.rst_o;
  assign trip_select = s.r0b[1:0];

  // ==========================================================================
  // Link domain: start detector on sda falling while scl high
  always_ff @(negedge sda_in or negedge arst_n) begin
    if (!arst_n) begin
      start_tgl <= 1'b0;
    end else if (scl) begin
      start_tgl <= ~start_tgl;
    end
  end

  // Next state of the link, sampled on scl rise
  always_comb begin
    next_l = l;
    mem_we = 1'b0;
    byte_in = {l.sh[6:0], sda_in};
    ld_byte = l.tgt_cmp ? s.rd_data : mem[l.mptr[AW-1:0]];
    next_l.lk_s1 = s.rst_oe;
    next_l.lk_s2 = l.lk_s1;
    next_l.wp_s1 = {s.r0b[snvc_pkg::PR_WP1], s.r0b[snvc_pkg::PR_WP0]};
    next_l.wp_s2 = l.wp_s1;
    next_l.a_s1 = target_select_pins;
    next_l.a_s2 = l.a_s1;
    next_l.start_seen = start_tgl;
    if (start_tgl != l.start_seen) begin
      next_l.st = snvc_pkg::L_ADDR;
      next_l.bitc = 4'h1;
      next_l.sh = {7'h00, sda_in};
      next_l.drive = 1'b0;
    end else if (l.lk_s2) begin
      next_l.st = snvc_pkg::L_IDLE;
      next_l.drive = 1'b0;
    end else if (l.st == snvc_pkg::L_RD) begin
      if (l.bitc < 4'h7) begin
        next_l.sh = {l.sh[6:0], 1'b0};
        next_l.drive = ~l.sh[6];
        next_l.bitc = l.bitc + 4'h1;
      end else if (l.bitc == 4'h7) begin
        next_l.drive = 1'b0;
        next_l.bitc = 4'h8;
      end else if (!sda_in) begin
        next_l.sh = ld_byte;
        next_l.drive = ~ld_byte[7];
        next_l.bitc = 4'h0;
        if (l.tgt_cmp) begin
          next_l.rptr = l.rptr + 5'h01;
          next_l.rd_addr = l.rptr + 5'h01;
          next_l.rd_tgl = ~l.rd_tgl;
        end else begin
          next_l.mptr = l.mptr + 15'h0001;
        end
      end else begin
        next_l.st = snvc_pkg::L_IDLE;
      end
    end else if (l.st != snvc_pkg::L_IDLE) begin
      if (l.bitc < 4'h7) begin
        next_l.sh = byte_in;
        next_l.bitc = l.bitc + 4'h1;
      end else if (l.bitc == 4'h7) begin
        next_l.bitc = 4'h8;
        next_l.sh = byte_in;
        next_l.drive = 1'b1;
        unique case (l.st)
          snvc_pkg::L_ADDR: begin
            next_l.tgt_cmp = (byte_in[7:4] == snvc_pkg::CMP_ID);
            next_l.rw = byte_in[0];
            next_l.drive = (byte_in[7:4] == snvc_pkg::CMP_ID || byte_in[7:4] == snvc_pkg::MEM_ID)
              && (byte_in[2:1] == l.a_s2);
          end
          snvc_pkg::L_AHI: next_l.hi = byte_in;
          snvc_pkg::L_ALO: begin
            if (l.tgt_cmp) begin
              next_l.rptr = byte_in[4:0];
              next_l.rd_addr = byte_in[4:0];
              next_l.rd_tgl = ~l.rd_tgl;
            end else begin
              next_l.mptr = {l.hi[6:0], byte_in};
            end
          end
          default: begin
            if (l.tgt_cmp) begin
              next_l.wr_addr = l.rptr;
              next_l.wr_data = byte_in;
              next_l.wr_tgl = ~l.wr_tgl;
              next_l.rptr = l.rptr + 5'h01;
              next_l.rd_addr = l.rptr + 5'h01;
              next_l.rd_tgl = ~l.rd_tgl;
            end else if (snvc_prot(l.mptr[AW-1:0], l.wp_s2)) begin
              next_l.drive = 1'b0;
            end else begin
              mem_we = 1'b1;
              next_l.mptr = l.mptr + 15'h0001;
            end
          end
        endcase
      end else begin
        next_l.bitc = 4'h0;
        next_l.drive = 1'b0;
        if (!l.drive) begin
          next_l.st = snvc_pkg::L_IDLE;
        end else begin
          unique case (l.st)
            snvc_pkg::L_ADDR: begin
              if (l.rw) begin
                next_l.st = snvc_pkg::L_RD;
                next_l.sh = ld_byte;
                next_l.drive = ~ld_byte[7];
                if (l.tgt_cmp) begin
                  next_l.rptr = l.rptr + 5'h01;
                  next_l.rd_addr = l.rptr + 5'h01;
                  next_l.rd_tgl = ~l.rd_tgl;
                end else begin
                  next_l.mptr = l.mptr + 15'h0001;
                end
              end else begin
                next_l.st = l.tgt_cmp ? snvc_pkg::L_ALO : snvc_pkg::L_AHI;
              end
            end
            snvc_pkg::L_AHI: next_l.st = snvc_pkg::L_ALO;
            snvc_pkg::L_ALO: next_l.st = snvc_pkg::L_WR;
            default: next_l.st = snvc_pkg::L_WR;
          endcase
        end
      end
    end
  end

  // Link register
  always_ff @(posedge scl or negedge arst_n) begin
    if (!arst_n) begin
      l <= '0;
      l.st <= snvc_pkg::L_IDLE;
      l.lk_s1 <= 1'b1;
      l.lk_s2 <= 1'b1;
    end else begin
      l <= next_l;
    end
  end

  // Memory array, written in the same scl cycle as the byte ends
  always_ff @(posedge scl) begin
    if (mem_we) begin
      mem[l.mptr[AW-1:0]] <= byte_in;
    end
  end

  // Drive the data line after scl falls
  always_ff @(negedge scl or negedge arst_n) begin
    if (!arst_n) begin
      sda_oe <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      sda_oe <= l.drive;
      sda_o <= 1'b0;
    end
  end

  // ==========================================================================
  // Checks
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hlen <= 32'h0;
    end else begin
      hlen <= s.rst_oe ? hlen + 32'h1 : 32'h0;
    end
  end

  supply_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    !s.vdd_s2 |=> s.rst_oe) else $error("reset not held during supply fault");
  pulse_len_a: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(s.rst_oe) |-> (hlen >= 32'(TICK_CYCLES))) else $error("reset pulse too short");
  wd_fire_a: assert property (@(posedge clk) disable iff (!arst_n)
    wd_exp && s.vdd_s2 |=> s.rst_oe && s.wtr) else $error("watchdog expiry lost");
  por_flag_a: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(s.vdd_s2) |-> ##1 s.por [*2]) else $error("supply fault flag not set");
  kick_only_a: assert property (@(posedge clk) disable iff (!arst_n)
    wr_go && l.wr_addr == snvc_pkg::REG_FLAGS && d[3:0] != snvc_pkg::KICK_PATTERN
    && !tick && s.vdd_s2 && !manual && !wd_exp |=> s.wd_cnt == $past(s.wd_cnt))
    else $error("watchdog restarted by wrong pattern");
  edge_count_a: assert property (@(posedge clk) disable iff (!arst_n)
    hit[0] && pwr && !ctr_wr && !s.r0c[snvc_pkg::EV_CC]
    |=> s.c1 == $past(s.c1) + 16'h0001) else $error("event edge not counted");
  sn_lock_a: assert property (@(posedge clk) disable iff (!arst_n)
    s.r0b[snvc_pkg::PR_SNL] |=> s.r0b[snvc_pkg::PR_SNL] && $stable(s.sn))
    else $error("locked serial number changed");
  prot_nack_a: assert property (@(posedge scl) disable iff (!arst_n)
    l.st == snvc_pkg::L_WR && !l.tgt_cmp && l.bitc == 4'h7 && !l.lk_s2
    && start_tgl == l.start_seen && snvc_prot(l.mptr[AW-1:0], l.wp_s2)
    |=> !l.drive && $stable(l.mptr)) else $error("protected byte acknowledged");
  cmp_ptr_a: assert property (@(posedge scl) disable iff (!arst_n)
    l.tgt_cmp && l.st != snvc_pkg::L_ADDR |=> $stable(l.mptr))
    else $error("companion access moved memory pointer");
  lockout_a: assert property (@(posedge scl) disable iff (!arst_n)
    l.lk_s2 && start_tgl == l.start_seen |=> l.st == snvc_pkg::L_IDLE && !l.drive)
    else $error("bus served during reset");

endmodule

`default_nettype wire

//--- snvc_top_test.sv
// Self-checking bench for the memory and companion target.
// Assumes snvc_host_model as the bus controller and pull-ups on sda and reset.
`timescale 1ns/1ps
`default_nettype none

module snvc_top_test;
  localparam int TICK = 400;
  localparam logic [8:0] AD [5] = '{9'h07F, 9'h080, 9'h0FF, 9'h100, 9'h1FF};
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic vdd_ok = 1'b1;
  logic bk = 1'b1;
  logic ext_rst = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [1:0] ev = 2'h0;
  logic [1:0] trip;
  logic scl, host_oe, sda_o, sda_oe, rst_o, rst_oe, ack;
  logic [7:0] mexp [512];
  int mismatches = 0;
  int n_checks = 0;
  int seed = 32'h2f5a2ae7;
  // Open-drain wires with pull-ups
  wire logic sda_w = (sda_oe ? sda_o : 1'b1) & ~host_oe;
  wire logic rst_w = (rst_oe ? rst_o : 1'b1) & ~ext_rst;

  // ==========================================================================
  // Clock and instances
  always #12.5 clk = ~clk;

  snvc_top #(.MEM_BYTES(512), .TICK_CYCLES(TICK), .DEB_CYCLES(20)) u_snvc_top (
    .clk(clk), .arst_n(arst_n), .scl(scl), .sda_in(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
    .target_select_pins(sel), .vdd_ok(vdd_ok), .trip_select(trip), .rst_pin_in(rst_w),
    .rst_pin_o(rst_o), .rst_pin_oe(rst_oe), .event_edge_inputs(ev), .backup_supply_pin(bk));

  snvc_host_model u_snvc_host_model (.scl(scl), .sda_oe(host_oe), .sda_in(sda_w));

  // ==========================================================================
  // Compare, protection map and closing
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic prot_hit(input logic [8:0] a, input logic [1:0] lv);
    return (lv == 2'h3) || (lv == 2'h2 && a < 9'h100) || (lv == 2'h1 && a < 9'h080);
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Bus helpers built on the host model
  task automatic addr(input logic [3:0] id, input logic rw);
    u_snvc_host_model.bus_start();
    u_snvc_host_model.put_byte({id, 1'b0, sel, rw}, ack);
  endtask

  task automatic put(input logic [7:0] b);
    u_snvc_host_model.put_byte(b, ack);
  endtask

  task automatic get(output logic [7:0] b);
    u_snvc_host_model.get_byte(1'b0, b);
    u_snvc_host_model.bus_stop();
  endtask

  task automatic cwr(input logic [7:0] idx, input logic [7:0] v);
    addr(snvc_pkg::CMP_ID, 1'b0);
    put(idx);
    put(v);
    u_snvc_host_model.bus_stop();
  endtask

  task automatic crd(input logic [7:0] idx, output logic [7:0] v);
    addr(snvc_pkg::CMP_ID, 1'b0);
    put(idx);
    addr(snvc_pkg::CMP_ID, 1'b1);
    get(v);
  endtask

  // Two address bytes always precede memory write data
  task automatic mset(input logic [8:0] a);
    addr(snvc_pkg::MEM_ID, 1'b0);
    put({7'h00, a[8]});
    put(a[7:0]);
  endtask

  // Wait out a reset pulse, then clock the link lockout clear
  task automatic settle();
    int n;
    n = 0;
    while (rst_oe !== 1'b0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk("reset end", 16'h0, 16'(rst_oe));
    addr(4'h0, 1'b0);
    u_snvc_host_model.bus_stop();
  endtask

  // ==========================================================================
  // Hang guard
  initial begin
    #2_000_000;
    mismatches++;
    finish_test();
  end

  // ==========================================================================
  // Test sequence
  initial begin
    logic [7:0] v;
    logic [31:0] r;
    int n;
    repeat (10) @(posedge clk);
    chk("reset during arst", 16'h1, 16'(rst_oe));
    arst_n <= 1'b1;
    r = $random(seed);
    sel <= r[1:0];
    settle();
    crd(8'h09, v);
    chk("supply flag", 16'h1, 16'(v[snvc_pkg::FLG_POR]));
    cwr(8'h09, 8'h00);
    $display("test reset done");
    // Counters run on backup while the supply is low
    cwr(8'h0C, 8'h01);
    @(posedge clk);
    vdd_ok <= 1'b0;
    r = $random(seed);
    n = 1 + int'(r[2:0]);
    repeat (6) @(posedge clk);
    chk("reset on low supply", 16'h1, 16'(rst_oe));
    repeat (n) begin
      repeat (4) @(posedge clk);
      ev <= 2'h3;
      repeat (4) @(posedge clk);
      ev <= 2'h0;
    end
    repeat (4) @(posedge clk);
    ev <= 2'h1;
    repeat (4) @(posedge clk);
    vdd_ok <= 1'b1;
    r = 0;
    while (rst_oe !== 1'b0 && r < 1000) begin
      @(posedge clk);
      r++;
    end
    chk("supply pulse", 16'h1, 16'(r >= TICK && r <= TICK + 8));
    settle();
    cwr(8'h0C, 8'h09);
    crd(8'h0D, v);
    chk("counter1 rising", 16'(n + 1), 16'(v));
    crd(8'h0F, v);
    chk("counter2 falling", 16'(n), 16'(v));
    $display("test counters done");
    // Protect levels and trip codes, every code
    for (int lv = 0; lv < 4; lv++) begin
      cwr(8'h0B, {3'h0, 2'(lv), 1'b0, 2'(lv)});
      repeat (4) @(posedge clk);
      chk("trip select", 16'(lv), 16'(trip));
      for (int i = 0; i < 5; i++) begin
        r = $random(seed);
        mset(AD[i]);
        put(r[7:0]);
        u_snvc_host_model.bus_stop();
        chk("data ack", 16'(!prot_hit(AD[i], 2'(lv))), 16'(ack));
        if (!prot_hit(AD[i], 2'(lv))) begin
          mexp[AD[i]] = r[7:0];
        end
      end
    end
    cwr(8'h0B, 8'h00);
    for (int i = 0; i < 5; i++) begin
      mset(AD[i]);
      addr(snvc_pkg::MEM_ID, 1'b1);
      get(v);
      chk("memory byte", 16'(mexp[AD[i]]), 16'(v));
    end
    // Companion access between memory reads keeps the pointer
    mset(AD[0]);
    addr(snvc_pkg::MEM_ID, 1'b1);
    get(v);
    crd(8'h0B, v);
    addr(snvc_pkg::MEM_ID, 1'b1);
    get(v);
    chk("pointer kept", 16'(mexp[AD[0] + 9'h001]), 16'(v));
    $display("test memory done");
    // Wrong select pins get no answer
    u_snvc_host_model.bus_start();
    u_snvc_host_model.put_byte({snvc_pkg::MEM_ID, 1'b0, ~sel, 1'b1}, ack);
    u_snvc_host_model.bus_stop();
    chk("select mismatch ack", 16'h0, 16'(ack));
    $display("test select done");
    // Short glitch ignored, long low makes a reset pulse
    @(posedge clk);
    ext_rst <= 1'b1;
    repeat (5) @(posedge clk);
    ext_rst <= 1'b0;
    repeat (10) @(posedge clk);
    chk("glitch filtered", 16'h0, 16'(rst_oe));
    ext_rst <= 1'b1;
    repeat (40) @(posedge clk);
    ext_rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk("manual pulse", 16'h1, 16'(rst_oe));
    settle();
    $display("test manual done");
    // Watchdog kept alive by the restart nibble, then left to expire
    cwr(8'h0A, 8'h03);
    cwr(8'h09, 8'h0A);
    cwr(8'h0A, 8'h83);
    repeat (4) begin
      repeat (300) @(posedge clk);
      cwr(8'h09, 8'h0A);
      chk("kicked watchdog quiet", 16'h0, 16'(rst_oe));
    end
    cwr(8'h09, 8'h05);
    n = 0;
    while (rst_oe !== 1'b1 && n < 1200) begin
      @(posedge clk);
      n++;
    end
    chk("watchdog expiry", 16'h1, 16'(rst_oe));
    settle();
    crd(8'h09, v);
    chk("watchdog flag", 16'h1, 16'(v[snvc_pkg::FLG_WTR]));
    cwr(8'h0A, 8'h00);
    $display("test watchdog done");
    // Serial number byte keeps its value once the lock is set
    r = $random(seed);
    cwr(8'h11, r[7:0]);
    cwr(8'h0B, 8'h80);
    cwr(8'h11, ~r[7:0]);
    crd(8'h11, v);
    chk("serial locked", 16'(r[7:0]), 16'(v));
    $display("test serial done");
    finish_test();
  end
endmodule
`default_nettype wire
